// *** ldc_char_ram.sv ***
// Display RAM with one write port and three registered read ports
`timescale 1ns/10ps
`default_nettype none
module ldc_char_ram (
    input  wire logic                         i_mclk,
    input  wire logic                         i_rst_n,
    input  wire logic                         i_we,
    input  wire logic [ldc_pkg::RAM_AW-1:0]   i_waddr,
    input  wire logic [7:0]                   i_wdata,
    input  wire logic [ldc_pkg::RAM_AW-1:0]   i_raddr_a,
    input  wire logic [ldc_pkg::RAM_AW-1:0]   i_raddr_b,
    input  wire logic [ldc_pkg::RAM_AW-1:0]   i_raddr_c,
    output logic      [7:0]                   o_rdata_a,
    output logic      [7:0]                   o_rdata_b,
    output logic      [7:0]                   o_rdata_c
);
    import ldc_pkg::*;

    logic [7:0] mem [RAM_DEPTH];

    always_ff @(posedge i_mclk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata_a <= BYTE_ZERO;
            o_rdata_b <= BYTE_ZERO;
            o_rdata_c <= BYTE_ZERO;
        end else begin
            o_rdata_a <= mem[i_raddr_a];
            o_rdata_b <= mem[i_raddr_b];
            o_rdata_c <= mem[i_raddr_c];
        end
    end
endmodule
`default_nettype wire

// *** ldc_host_model.sv ***
// Host processor bus model that reaches the LCD data control block
`timescale 1ns/10ps
`default_nettype none
module ldc_host_model (
    input  wire logic       i_mclk,
    input  wire logic       i_async_ready,
    input  wire logic [7:0] i_data,
    input  wire logic       i_data_oe,
    input  wire logic       i_ctrl_enable,
    input  wire logic       i_ctrl_rw,
    output logic            o_display_chip_select_n,
    output logic            o_register_select,
    output logic            o_rd_n,
    output logic            o_wr_n,
    output logic      [7:0] o_data
);
    logic seen_en;
    logic seen_rw;
    logic seen_oe;

    initial begin
        o_display_chip_select_n = 1'b1;
        o_register_select = 1'b0;
        o_rd_n = 1'b1;
        o_wr_n = 1'b1;
        o_data = 8'h00;
    end

    // One byte access; select and strobe held until ready returns
    task automatic access(input logic rs, input logic wr, input logic [7:0] wd,
                          output logic [7:0] rd, output int lows);
        int n;
        n = 0;
        lows = 0;
        @(posedge i_mclk);
        o_display_chip_select_n <= 1'b0;
        o_register_select <= rs;
        o_rd_n <= wr;
        o_wr_n <= !wr;
        o_data <= wd;
        @(posedge i_mclk);
        while (i_async_ready !== 1'b0 && n < 20) begin
            @(posedge i_mclk);
            n++;
        end
        seen_en = i_ctrl_enable;
        seen_rw = i_ctrl_rw;
        while (i_async_ready !== 1'b1 && n < 40) begin
            @(posedge i_mclk);
            n++;
            lows++;
        end
        rd = i_data;
        seen_oe = i_data_oe;
        if (n >= 40)
            lows = -1;
        o_display_chip_select_n <= 1'b1;
        o_rd_n <= 1'b1;
        o_wr_n <= 1'b1;
        o_data <= ~wd;
        o_register_select <= ~rs;
        repeat (4) @(posedge i_mclk);
    endtask

    // Read strobe with no chip select; flags any change on ready or enable
    task automatic stray_read(input int cycles, output logic moved);
        moved = 1'b0;
        @(posedge i_mclk);
        o_rd_n <= 1'b0;
        repeat (cycles) begin
            @(posedge i_mclk);
            if (i_async_ready !== 1'b1 || i_ctrl_enable !== 1'b0)
                moved = 1'b1;
        end
        o_rd_n <= 1'b1;
        repeat (4) @(posedge i_mclk);
    endtask
endmodule
`default_nettype wire

// *** ldc_lcd_ctrl.sv ***
// LCD data control: clock divider, host bus glue and panel scan
`timescale 1ns/10ps
`default_nettype none
module ldc_lcd_ctrl (
    input  wire logic        i_mclk,
    input  wire logic        i_rst_n,
    input  wire logic        i_display_chip_select_n,
    input  wire logic        i_register_select,
    input  wire logic        i_rd_n,
    input  wire logic        i_wr_n,
    input  wire logic [7:0]  i_data,
    output logic      [7:0]  o_data,
    output logic             o_data_oe,
    output logic             o_async_ready,
    output logic             o_ctrl_enable,
    output logic             o_ctrl_rw,
    output logic             o_clk_500k_tp,
    output logic             o_upper_serial_pixels,
    output logic             o_lower_serial_pixels,
    output logic             o_frame_marker,
    output logic             o_row_latch_strobe,
    output logic             o_pixel_shift_clock,
    output logic             o_ac_phase
);
    import ldc_pkg::*;

    // Pin synchronisers; logic reads the second stage only
    logic [11:0] pin_m_ff, pin_s_ff;
    logic        cs_n_s_ff, rs_s_ff, rd_n_s_ff, wr_n_s_ff;
    logic [7:0]  data_s_ff;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_m_ff <= {1'b1, DATA_PORT_OFS, 1'b1, 1'b1, BYTE_ZERO};
            pin_s_ff <= {1'b1, DATA_PORT_OFS, 1'b1, 1'b1, BYTE_ZERO};
        end else begin
            pin_m_ff <= {i_display_chip_select_n, i_register_select, i_rd_n, i_wr_n, i_data};
            pin_s_ff <= pin_m_ff;
        end
    end
    assign {cs_n_s_ff, rs_s_ff, rd_n_s_ff, wr_n_s_ff, data_s_ff} = pin_s_ff;

    // Clock divider: 40 MHz -> 10 MHz tick -> decade -> 500 kHz
    logic [1:0] pre_ff, nxt_pre;
    logic [3:0] dec_ff, nxt_dec;
    logic       clk500_ff, nxt_clk500;
    logic       board_tick, tick_1m, shift_tick, fall_tick;
    always_comb begin
        board_tick = (pre_ff == PRESCALE_LAST);
        tick_1m    = board_tick && (dec_ff == DECADE_LAST);
        shift_tick = tick_1m && !clk500_ff;
        fall_tick  = tick_1m && clk500_ff;
        nxt_pre    = board_tick ? 2'h0 : pre_ff + 2'h1;
        nxt_dec    = dec_ff;
        if (board_tick) begin
            nxt_dec = (dec_ff == DECADE_LAST) ? 4'h0 : dec_ff + 4'h1;
        end
        nxt_clk500 = tick_1m ? !clk500_ff : clk500_ff;
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pre_ff        <= 2'h0;
            dec_ff        <= 4'h0;
            clk500_ff     <= 1'b0;
            o_clk_500k_tp <= 1'b0;
        end else begin
            pre_ff        <= nxt_pre;
            dec_ff        <= nxt_dec;
            clk500_ff     <= nxt_clk500;
            o_clk_500k_tp <= nxt_clk500;
        end
    end

    // Host bus glue and controller registers
    ldc_bus_state_t bus_ff, nxt_bus;
    logic [3:0] wcnt_ff, nxt_wcnt;
    logic [7:0] ir_ff, nxt_ir, mode_ff, nxt_mode, cursor_ff, nxt_cursor, nxt_data, ram_rdata;
    logic       rs_hold_ff, nxt_rs_hold, nxt_ready, nxt_enable, nxt_rw, nxt_oe, ram_we, host_req;
    always_comb begin
        host_req    = !cs_n_s_ff && (!rd_n_s_ff || !wr_n_s_ff);
        nxt_bus     = bus_ff;
        nxt_wcnt    = wcnt_ff;
        nxt_ir      = ir_ff;
        nxt_mode    = mode_ff;
        nxt_cursor  = cursor_ff;
        nxt_data    = o_data;
        nxt_rs_hold = rs_hold_ff;
        nxt_ready   = o_async_ready;
        nxt_enable  = o_ctrl_enable;
        nxt_rw      = o_ctrl_rw;
        nxt_oe      = o_data_oe;
        ram_we      = 1'b0;
        case (bus_ff)
            BUS_IDLE: begin
                if (host_req) begin
                    nxt_bus     = BUS_WAIT;
                    nxt_wcnt    = WAIT_STATES - 4'h1;
                    nxt_ready   = 1'b0;
                    nxt_enable  = 1'b1;
                    nxt_rw      = !rd_n_s_ff;
                    nxt_rs_hold = rs_s_ff;
                end
            end
            BUS_WAIT: begin
                if (wcnt_ff == 4'h0) begin
                    nxt_bus = BUS_STROBE;
                end else begin
                    nxt_wcnt = wcnt_ff - 4'h1;
                end
            end
            BUS_STROBE: begin
                nxt_bus    = BUS_DONE;
                nxt_ready  = 1'b1;
                nxt_enable = 1'b0;
                if (o_ctrl_rw) begin
                    nxt_oe = 1'b1;
                    if (rs_hold_ff == INSTR_PORT_OFS) begin
                        nxt_data = BYTE_ZERO;
                        nxt_data[STATUS_CHAR_BIT] = 1'b1;
                    end else if (ir_ff == INS_READ) begin
                        nxt_data   = ram_rdata;
                        nxt_cursor = cursor_ff + 8'h01;
                    end else begin
                        nxt_data = BYTE_ZERO;
                    end
                end else if (rs_hold_ff == INSTR_PORT_OFS) begin
                    nxt_ir = data_s_ff;
                end else begin
                    case (ir_ff)
                        INS_MODE: begin
                            nxt_mode = data_s_ff;
                            nxt_mode[GRAPHIC_BIT] = 1'b0;
                        end
                        INS_CURSOR: nxt_cursor = data_s_ff;
                        INS_WRITE: begin
                            ram_we     = 1'b1;
                            nxt_cursor = cursor_ff + 8'h01;
                        end
                        default: nxt_cursor = cursor_ff;
                    endcase
                end
            end
            BUS_DONE: begin
                if (!host_req) begin
                    nxt_bus = BUS_IDLE;
                    nxt_oe  = 1'b0;
                end
            end
            default: nxt_bus = BUS_IDLE;
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bus_ff        <= BUS_IDLE;
            wcnt_ff       <= 4'h0;
            ir_ff         <= INSTR_RESET;
            mode_ff       <= MODE_RESET;
            cursor_ff     <= CURSOR_RESET;
            rs_hold_ff    <= DATA_PORT_OFS;
            o_data        <= BYTE_ZERO;
            o_data_oe     <= 1'b0;
            o_async_ready <= 1'b1;
            o_ctrl_enable <= 1'b0;
            o_ctrl_rw     <= 1'b1;
        end else begin
            bus_ff        <= nxt_bus;
            wcnt_ff       <= nxt_wcnt;
            ir_ff         <= nxt_ir;
            mode_ff       <= nxt_mode;
            cursor_ff     <= nxt_cursor;
            rs_hold_ff    <= nxt_rs_hold;
            o_data        <= nxt_data;
            o_data_oe     <= nxt_oe;
            o_async_ready <= nxt_ready;
            o_ctrl_enable <= nxt_enable;
            o_ctrl_rw     <= nxt_rw;
        end
    end

    // Panel scan, paced by the 500 kHz controller clock
    logic [2:0] bit_ff, nxt_bit, col_ff, nxt_col;
    logic [3:0] row_ff, nxt_row;
    logic [7:0] sh_up_ff, nxt_sh_up, sh_lo_ff, nxt_sh_lo, up_byte, lo_byte;
    logic       row_end_ff, nxt_row_end, nxt_upper, nxt_lower, nxt_frame, nxt_latch, nxt_shclk, nxt_phase, disp_on;
    ldc_char_ram u_ram (
        .i_mclk    (i_mclk),    .i_rst_n   (i_rst_n),   .i_we      (ram_we),
        .i_waddr   (cursor_ff), .i_wdata   (data_s_ff), .i_raddr_c (cursor_ff),
        .i_raddr_a ({1'b0, row_ff, col_ff}),            .i_raddr_b ({1'b1, row_ff, col_ff}),
        .o_rdata_a (up_byte),   .o_rdata_b (lo_byte),   .o_rdata_c (ram_rdata)
    );

    always_comb begin
        disp_on     = mode_ff[DISPLAY_ON_BIT];
        nxt_bit     = bit_ff;
        nxt_col     = col_ff;
        nxt_row     = row_ff;
        nxt_sh_up   = sh_up_ff;
        nxt_sh_lo   = sh_lo_ff;
        nxt_row_end = row_end_ff;
        nxt_upper   = o_upper_serial_pixels;
        nxt_lower   = o_lower_serial_pixels;
        nxt_frame   = o_frame_marker;
        nxt_latch   = o_row_latch_strobe;
        nxt_phase   = o_ac_phase;
        nxt_shclk   = fall_tick ? 1'b1 : o_pixel_shift_clock;
        if (shift_tick) begin
            nxt_shclk = 1'b0;
            if (bit_ff == 3'h0) begin
                nxt_upper = up_byte[7] && disp_on;
                nxt_lower = lo_byte[7] && disp_on;
                nxt_sh_up = {up_byte[6:0], 1'b0};
                nxt_sh_lo = {lo_byte[6:0], 1'b0};
            end else begin
                nxt_upper = sh_up_ff[7] && disp_on;
                nxt_lower = sh_lo_ff[7] && disp_on;
                nxt_sh_up = {sh_up_ff[6:0], 1'b0};
                nxt_sh_lo = {sh_lo_ff[6:0], 1'b0};
            end
            nxt_bit     = bit_ff + 3'h1;
            nxt_row_end = (bit_ff == BIT_LAST) && (col_ff == COL_LAST);
            nxt_latch   = row_end_ff;
            nxt_frame   = row_end_ff && (row_ff == 4'h0);
            if (row_end_ff && (row_ff == 4'h0)) begin
                nxt_phase = !o_ac_phase;
            end
            if (bit_ff == BIT_LAST) begin
                nxt_col = col_ff + 3'h1;
                if (col_ff == COL_LAST) begin
                    nxt_row = (row_ff == ROW_LAST) ? 4'h0 : row_ff + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bit_ff                <= 3'h0;
            col_ff                <= 3'h0;
            row_ff                <= 4'h0;
            sh_up_ff              <= BYTE_ZERO;
            sh_lo_ff              <= BYTE_ZERO;
            row_end_ff            <= 1'b0;
            o_upper_serial_pixels <= 1'b0;
            o_lower_serial_pixels <= 1'b0;
            o_frame_marker        <= 1'b0;
            o_row_latch_strobe    <= 1'b0;
            o_pixel_shift_clock   <= 1'b0;
            o_ac_phase            <= 1'b0;
        end else begin
            bit_ff                <= nxt_bit;
            col_ff                <= nxt_col;
            row_ff                <= nxt_row;
            sh_up_ff              <= nxt_sh_up;
            sh_lo_ff              <= nxt_sh_lo;
            row_end_ff            <= nxt_row_end;
            o_upper_serial_pixels <= nxt_upper;
            o_lower_serial_pixels <= nxt_lower;
            o_frame_marker        <= nxt_frame;
            o_row_latch_strobe    <= nxt_latch;
            o_pixel_shift_clock   <= nxt_shclk;
            o_ac_phase            <= nxt_phase;
        end
    end

    // Checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    sequence wait_phase_s;
        (bus_ff == BUS_WAIT) [*4];
    endsequence
    sequence strobe_then_ready_s;
        (bus_ff == BUS_STROBE) && !o_async_ready ##1 o_async_ready;
    endsequence

    decade_wrap_a: assert property (board_tick && dec_ff == DECADE_LAST |=> dec_ff == 4'h0)
        else $error("decade counter did not restart after nine");
    decade_bound_a: assert property (dec_ff <= DECADE_LAST)
        else $error("decade counter passed nine");
    half_clock_a: assert property (tick_1m |=> (o_clk_500k_tp != $past(o_clk_500k_tp)) ##1 $stable(o_clk_500k_tp))
        else $error("500 kHz clock did not toggle once per 1 MHz tick");
    char_mode_a: assert property (!mode_ff[GRAPHIC_BIT])
        else $error("graphic mode became set");
    cs_gate_a: assert property (bus_ff == BUS_IDLE && cs_n_s_ff |=> bus_ff == BUS_IDLE && !o_ctrl_enable)
        else $error("access started without chip select");
    instr_write_a: assert property (bus_ff == BUS_STROBE && !o_ctrl_rw && rs_hold_ff |=> ir_ff == $past(data_s_ff))
        else $error("instruction register write lost");
    wait_len_a: assert property ($rose(bus_ff == BUS_WAIT) |-> wait_phase_s ##1 strobe_then_ready_s)
        else $error("wait state count wrong");
    enable_dir_a: assert property ($rose(o_ctrl_enable) |-> o_ctrl_rw == !$past(rd_n_s_ff) && !o_async_ready)
        else $error("enable or direction wrong");
    ram_write_a: assert property (ram_we |-> bus_ff == BUS_STROBE && ir_ff == INS_WRITE && !rs_hold_ff)
        else $error("display RAM written outside a data write");
    shift_clk_a: assert property (shift_tick |=> !o_pixel_shift_clock ##40 $rose(o_pixel_shift_clock))
        else $error("pixel shift clock low half wrong");
    ac_phase_a: assert property ($rose(o_frame_marker) |-> o_ac_phase != $past(o_ac_phase))
        else $error("AC phase did not turn with the frame");
endmodule
`default_nettype wire

// *** ldc_pkg.sv ***
// Constants and types for the LCD data control block
package ldc_pkg;
    // Clock rates
    localparam int unsigned MCLK_HZ        = 40_000_000;
    localparam int unsigned BOARD_HZ       = 10_000_000;
    localparam logic [1:0]  PRESCALE_LAST  = 2'(MCLK_HZ / BOARD_HZ - 1);
    localparam logic [3:0]  DECADE_LAST    = 4'h9;
    // Controller access time, rounded up to whole master clocks
    localparam int unsigned CTRL_ACCESS_NS = 100;
    localparam logic [3:0]  WAIT_STATES    = 4'((CTRL_ACCESS_NS * (MCLK_HZ / 1_000_000) + 999) / 1000);
    // Register offsets (register select level)
    localparam logic        DATA_PORT_OFS  = 1'b0;
    localparam logic        INSTR_PORT_OFS = 1'b1;
    // Instruction codes held in the instruction register
    localparam logic [7:0]  INS_MODE       = 8'h00;
    localparam logic [7:0]  INS_CURSOR     = 8'h0A;
    localparam logic [7:0]  INS_WRITE      = 8'h0C;
    localparam logic [7:0]  INS_READ       = 8'h0D;
    // Mode and status fields
    localparam int unsigned GRAPHIC_BIT    = 3;
    localparam int unsigned DISPLAY_ON_BIT = 5;
    localparam int unsigned STATUS_CHAR_BIT = 0;
    localparam logic [7:0]  MODE_RESET     = 8'h20;
    localparam logic [7:0]  INSTR_RESET    = 8'h00;
    localparam logic [7:0]  CURSOR_RESET   = 8'h00;
    localparam logic [7:0]  BYTE_ZERO      = 8'h00;
    // Display RAM and scan geometry
    localparam int unsigned RAM_AW         = 8;
    localparam int unsigned RAM_DEPTH      = 256;
    localparam logic [2:0]  BIT_LAST       = 3'h7;
    localparam logic [2:0]  COL_LAST       = 3'h7;
    localparam logic [3:0]  ROW_LAST       = 4'hF;

    typedef enum logic [1:0] {
        BUS_IDLE   = 2'b00,
        BUS_WAIT   = 2'b01,
        BUS_STROBE = 2'b11,
        BUS_DONE   = 2'b10
    } ldc_bus_state_t;
endpackage

// *** test_lcd_data_control.sv ***
// Self-checking testbench for the LCD data control block
`timescale 1ns/10ps
`default_nettype none
`define LDC_CHK(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            miscompares++; \
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, (got), (exp)); \
        end \
    end
module test_lcd_data_control;
    import ldc_pkg::*;
    localparam int CYCLE_LIMIT = 100000;
    logic       i_mclk;
    logic       i_rst_n;
    wire logic  cs_n, rs, rd_n, wr_n;
    wire logic [7:0] wdata, rdata;
    wire logic  oe, ready, en, rw, tp, up, lo, fm, latch, shift, ac;
    int         comparisons, miscompares, cycles;

    ldc_host_model host (.i_mclk(i_mclk), .i_async_ready(ready), .i_data(rdata), .i_data_oe(oe),
        .i_ctrl_enable(en), .i_ctrl_rw(rw), .o_display_chip_select_n(cs_n), .o_register_select(rs),
        .o_rd_n(rd_n), .o_wr_n(wr_n), .o_data(wdata));

    ldc_lcd_ctrl dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_display_chip_select_n(cs_n),
        .i_register_select(rs), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_data(wdata), .o_data(rdata),
        .o_data_oe(oe), .o_async_ready(ready), .o_ctrl_enable(en), .o_ctrl_rw(rw),
        .o_clk_500k_tp(tp), .o_upper_serial_pixels(up), .o_lower_serial_pixels(lo),
        .o_frame_marker(fm), .o_row_latch_strobe(latch), .o_pixel_shift_clock(shift),
        .o_ac_phase(ac));

    initial i_mclk = 1'b0;
    always #12.5 i_mclk = ~i_mclk;

    task automatic wrap_up;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge i_mclk) begin
        cycles <= cycles + 1;
        if (cycles == CYCLE_LIMIT) begin
            miscompares++;
            $display("CHECK FAILED at %0t: run timed out", $time);
            wrap_up();
        end
    end

    task automatic put(input logic sel, input logic [7:0] d);
        logic [7:0] x;
        int l;
        host.access(sel, 1'b1, d, x, l);
        `LDC_CHK(l, int'(WAIT_STATES) + 1)
        `LDC_CHK({host.seen_en, host.seen_rw, host.seen_oe}, 3'b100)
    endtask

    task automatic get(input logic sel, output logic [7:0] d);
        int l;
        host.access(sel, 1'b0, 8'h00, d, l);
        `LDC_CHK(l, int'(WAIT_STATES) + 1)
        `LDC_CHK({host.seen_en, host.seen_rw, host.seen_oe}, 3'b111)
    endtask

    task automatic t_reset;
        `LDC_CHK({ready, rw, oe, en}, 4'b1100)
        `LDC_CHK({tp, fm, latch, shift, up, lo, ac}, 7'h00)
        $display("t_reset done");
    endtask

    task automatic t_no_select;
        logic moved;
        host.stray_read(12, moved);
        `LDC_CHK(moved, 1'b0)
        $display("t_no_select done");
    endtask

    task automatic t_status;
        logic [7:0] d;
        put(1'b1, INS_MODE);
        put(1'b0, 8'h28);
        get(1'b1, d);
        `LDC_CHK(d, 8'h01)
        $display("t_status done");
    endtask

    task automatic t_ram;
        logic [7:0] d;
        put(1'b1, INS_CURSOR);
        put(1'b0, 8'h00);
        put(1'b1, INS_WRITE);
        for (int i = 0; i < 8; i++)
            put(1'b0, (i == 0) ? 8'h80 : 8'h00);
        put(1'b1, INS_CURSOR);
        put(1'b0, 8'h80);
        put(1'b1, INS_WRITE);
        for (int i = 0; i < 8; i++)
            put(1'b0, (i == 7) ? 8'h01 : 8'h00);
        put(1'b1, INS_CURSOR);
        put(1'b0, 8'h00);
        put(1'b1, INS_READ);
        get(1'b0, d);
        `LDC_CHK(d, 8'h80)
        get(1'b0, d);
        `LDC_CHK(d, 8'h00)
        put(1'b1, INS_CURSOR);
        put(1'b0, 8'h87);
        put(1'b1, INS_READ);
        get(1'b0, d);
        `LDC_CHK(d, 8'h01)
        put(1'b1, INS_MODE);
        get(1'b0, d);
        `LDC_CHK(d, 8'h00)
        $display("t_ram done");
    endtask

    task automatic t_clock;
        int hi;
        int lw;
        hi = 0;
        lw = 0;
        while (tp !== 1'b0) @(posedge i_mclk);
        while (tp !== 1'b1) @(posedge i_mclk);
        while (tp === 1'b1) begin
            @(posedge i_mclk);
            hi++;
        end
        while (tp === 1'b0) begin
            @(posedge i_mclk);
            lw++;
        end
        `LDC_CHK(hi, 40)
        `LDC_CHK(lw, 40)
        $display("t_clock done");
    endtask

    task automatic t_panel;
        logic        ac_before;
        logic [63:0] upper_bits;
        logic [63:0] lower_bits;
        int          hi;
        hi = 0;
        ac_before = ac;
        while (fm !== 1'b1) begin
            ac_before = ac;
            @(posedge i_mclk);
        end
        upper_bits[63] = up;
        lower_bits[63] = lo;
        `LDC_CHK(latch, 1'b1)
        while (fm === 1'b1) begin
            @(posedge i_mclk);
            hi++;
        end
        `LDC_CHK(hi, 80)
        `LDC_CHK(ac, ~ac_before)
        for (int i = 1; i < 64; i++) begin
            @(posedge shift);
            upper_bits[63 - i] = up;
            lower_bits[63 - i] = lo;
        end
        `LDC_CHK(upper_bits, {1'b1, 63'h0})
        `LDC_CHK(lower_bits, 64'h1)
        put(1'b1, INS_MODE);
        put(1'b0, BYTE_ZERO);
        repeat (2) @(posedge shift);
        `LDC_CHK({up, lo}, 2'b00)
        $display("t_panel done");
    endtask

    initial begin
        comparisons = 0;
        miscompares = 0;
        cycles = 0;
        i_rst_n = 1'b0;
        repeat (2) @(posedge i_mclk);
        t_reset();
        i_rst_n <= 1'b1;
        repeat (2) @(posedge i_mclk);
        t_no_select();
        t_status();
        t_ram();
        t_clock();
        t_panel();
        wrap_up();
    end
endmodule
`default_nettype wire
